// file: difl_pkg.sv
`default_nettype none
package difl_pkg;
	// =============================================================
	// Register map (byte addresses, one aligned word each)
	// =============================================================
	localparam logic [7:0] ADDR_CFG     = 8'h00;
	localparam logic [7:0] ADDR_GAIN    = 8'h04;
	localparam logic [7:0] ADDR_SETTLE  = 8'h08;
	localparam logic [7:0] ADDR_STATUS  = 8'h0c;
	localparam logic [7:0] ADDR_ETOTAL  = 8'h10;
	localparam logic [7:0] ADDR_EDISP   = 8'h14;
	localparam logic [7:0] ADDR_FREQ    = 8'h18;
	localparam int         ADDR_W       = 8;

	// =============================================================
	// Codes and limits
	// =============================================================
	localparam logic [1:0]  CLR_SEL_STORE   = 2'h1;
	localparam logic [1:0]  MEM_SEL_STORE   = 2'h1;
	localparam logic [3:0]  METHOD_SLV      = 4'h3;
	localparam logic [3:0]  METHOD_SLV0HZ   = 4'h4;
	localparam logic [3:0]  METHOD_VEC_ENC  = 4'h5;
	localparam logic [9:0]  GAIN_MIN        = 10'h001;
	localparam logic [9:0]  GAIN_MAX        = 10'h3e8;
	localparam logic [9:0]  GAIN_RST        = 10'h001;
	localparam logic [15:0] SETTLE_RST      = 16'h0000;
	localparam logic [31:0] CFG_RST         = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam logic [1:0]  WARM_DONE       = 2'h3;

	// =============================================================
	// Terminal pin vector positions
	// =============================================================
	localparam int PIN_ECLR  = 0;
	localparam int PIN_SLOCK = 1;
	localparam int PIN_FLUX  = 2;
	localparam int PIN_HOLD  = 3;
	localparam int PIN_KEY   = 4;
	localparam int PIN_RUN   = 5;
	localparam int PIN_RST   = 6;
	localparam int PIN_UP    = 7;
	localparam int PIN_DN    = 8;
	localparam int PIN_POS   = 9;
	localparam int NPINS     = 12;

	// Configuration register layout.
	typedef struct packed {
		logic [13:0] rsvd;
		logic [1:0]  restart_after_coast_mode;
		logic [1:0]  updown_memory_select;
		logic [2:0]  pos_assigned;
		logic        hold_assigned;
		logic        eclr_assigned;
		logic        flux_assigned;
		logic        slock_assigned;
		logic [3:0]  control_method_select;
		logic [1:0]  energy_clear_select;
	} difl_cfg_type;

	// Status register layout.
	typedef struct packed {
		logic [23:0] rsvd;
		logic        holding;
		logic        settle_busy;
		logic [2:0]  pos_index;
		logic        excite;
		logic        coast_stop;
		logic        driving;
	} difl_status_type;

	// Drive state machine, one-hot.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_RUN   = 3'b010,
		ST_COAST = 3'b100
	} difl_state_type;
endpackage
`default_nettype wire

// file: difl_top.sv
`timescale 1ns/100ps
`default_nettype none
module difl_top
	import difl_pkg::*;
#(
	parameter int FREQ_W    = 16,   // Frequency reference width.
	parameter int FREQ_STEP = 1     // Up/down step per edge.
) (
	input  wire logic                aclk,            // Control clock, 40 MHz.
	input  wire logic                aresetn,         // Synchronous power-on reset.
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,    // Write address.
	input  wire logic                s_axi_awvalid,   // Write address valid.
	output logic                     s_axi_awready,   // Write address ready.
	input  wire logic [31:0]         s_axi_wdata,     // Write data.
	input  wire logic [3:0]          s_axi_wstrb,     // Write byte strobes.
	input  wire logic                s_axi_wvalid,    // Write data valid.
	output logic                     s_axi_wready,    // Write data ready.
	output logic [1:0]               s_axi_bresp,     // Write response.
	output logic                     s_axi_bvalid,    // Write response valid.
	input  wire logic                s_axi_bready,    // Write response ready.
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,    // Read address.
	input  wire logic                s_axi_arvalid,   // Read address valid.
	output logic                     s_axi_arready,   // Read address ready.
	output logic [31:0]              s_axi_rdata,     // Read data.
	output logic [1:0]               s_axi_rresp,     // Read response.
	output logic                     s_axi_rvalid,    // Read data valid.
	input  wire logic                s_axi_rready,    // Read data ready.
	input  wire logic                energy_clear_in, // Energy clear terminal.
	input  wire logic                servo_lock_in,   // Servo-lock terminal.
	input  wire logic                flux_forcing_in, // Flux-forcing terminal.
	input  wire logic                analog_hold_in,  // Analog hold terminal.
	input  wire logic                operator_store_key, // Operator store key.
	input  wire logic                run_cmd_in,      // Run command.
	input  wire logic                reset_terminal,  // Drive reset terminal.
	input  wire logic                freq_up_in,      // Frequency increment.
	input  wire logic                freq_down_in,    // Frequency decrement.
	input  wire logic                pos_sel_bit0,    // Position select LSB.
	input  wire logic                pos_sel_bit1,    // Position select middle.
	input  wire logic                pos_sel_bit2,    // Position select MSB.
	input  wire logic                energy_pulse,    // One energy unit, same clock.
	input  wire logic [FREQ_W-1:0]   analog_cmd,      // Analog command, same clock.
	input  wire logic [FREQ_W-1:0]   nv_restore_data, // Stored frequency at power-up.
	output logic                     nv_store_stb,    // Store strobe to nonvolatile.
	output logic [FREQ_W-1:0]        nv_store_data,   // Value to store.
	output logic [FREQ_W-1:0]        freq_ref,        // Frequency reference out.
	output logic                     drive_enable,    // Motor being driven.
	output logic                     coast_stop,      // Free-run coasting stop.
	output logic                     pre_excite,      // Pre-excitation current on.
	output logic                     restart_stb,     // Restart after coast pulse.
	output logic [1:0]               restart_mode,    // Restart-after-coast mode.
	output logic [2:0]               pos_index        // Selected position setting.
);
	// =============================================================
	// Terminal synchroniser
	// =============================================================
	logic [NPINS-1:0] pins;
	logic [NPINS-1:0] s1_q, s2_q, s3_q, stab_q, prev_q;
	logic [NPINS-1:0] rise, edge_any;

	assign pins = {pos_sel_bit2, pos_sel_bit1, pos_sel_bit0, freq_down_in, freq_up_in, reset_terminal,
		run_cmd_in, operator_store_key, analog_hold_in, flux_forcing_in, servo_lock_in, energy_clear_in};

	// Three stages; a level counts only once stages two and three agree, which filters a one-cycle glitch.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			stab_q <= '0;
			prev_q <= '0;
		end else begin
			s1_q   <= pins;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			stab_q <= (s3_q & ~(s2_q ^ s3_q)) | (stab_q & (s2_q ^ s3_q));
			prev_q <= stab_q;
		end
	end

	assign rise     = stab_q & ~prev_q;
	assign edge_any = stab_q ^ prev_q;

	// =============================================================
	// Register file
	// =============================================================
	difl_cfg_type    cfg_q;
	difl_status_type stat;
	logic [9:0]      gain_q;
	logic [15:0]     settle_q;
	logic [31:0]     etotal_q, edisp_q;
	logic [9:0]      escale_q;
	logic [FREQ_W-1:0] freq_q;
	logic            holding_q;

	// Byte-lane merge for a 32-bit register.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// =============================================================
	// AXI4-Lite slave
	// =============================================================
	logic              aw_have_q, w_have_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              wr_go;
	logic              wr_hit;
	logic [31:0]       gain_new, settle_new;

	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_hit        = (awaddr_q == ADDR_CFG) || (awaddr_q == ADDR_GAIN) || (awaddr_q == ADDR_SETTLE);
	assign gain_new      = merge({22'h0, gain_q}, wdata_q, wstrb_q);
	assign settle_new    = merge({16'h0, settle_q}, wdata_q, wstrb_q);

	// Address and data are taken in either order; the response follows both.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			awaddr_q     <= '0;
			wdata_q      <= '0;
			wstrb_q      <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Configuration writes; a gain outside 1..1000 is refused and the old gain stays.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q    <= difl_cfg_type'(CFG_RST);
			gain_q   <= GAIN_RST;
			settle_q <= SETTLE_RST;
		end else if (wr_go) begin
			if (awaddr_q == ADDR_CFG) begin
				cfg_q <= difl_cfg_type'(merge(cfg_q, wdata_q, wstrb_q) & {14'h0, 18'h3ffff});
			end
			if (awaddr_q == ADDR_GAIN && gain_new[31:10] == 22'h0 && gain_new[9:0] >= GAIN_MIN
				&& gain_new[9:0] <= GAIN_MAX) begin
				gain_q <= gain_new[9:0];
			end
			if (awaddr_q == ADDR_SETTLE) begin
				settle_q <= settle_new[15:0];
			end
		end
	end

	// Read channel answers one cycle after the address is taken.
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_CFG:    s_axi_rdata <= cfg_q;
				ADDR_GAIN:   s_axi_rdata <= {22'h0, gain_q};
				ADDR_SETTLE: s_axi_rdata <= {16'h0, settle_q};
				ADDR_STATUS: s_axi_rdata <= stat;
				ADDR_ETOTAL: s_axi_rdata <= etotal_q;
				ADDR_EDISP:  s_axi_rdata <= edisp_q;
				ADDR_FREQ:   s_axi_rdata <= 32'(freq_q);
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// =============================================================
	// Energy accumulator and display scaling
	// =============================================================
	logic eclr;

	assign eclr = (cfg_q.eclr_assigned && rise[PIN_ECLR])
		|| (cfg_q.energy_clear_select == CLR_SEL_STORE && rise[PIN_KEY]);

	// Display counts one unit per gain units of total; avoids a divider at the cost of a prescaler.
	always_ff @(posedge aclk) begin
		if (!aresetn || eclr) begin
			etotal_q <= '0;
			edisp_q  <= '0;
			escale_q <= '0;
		end else if (energy_pulse) begin
			etotal_q <= etotal_q + 32'h1;
			if (escale_q + 10'h1 >= gain_q) begin
				escale_q <= '0;
				edisp_q  <= edisp_q + 32'h1;
			end else begin
				escale_q <= escale_q + 10'h1;
			end
		end
	end

	// =============================================================
	// Run gating and coasting stop
	// =============================================================
	logic flux_ok, slock_ok, gate, soft_rst;
	difl_state_type st_q;

	assign flux_ok  = cfg_q.flux_assigned && (cfg_q.control_method_select == METHOD_SLV
		|| cfg_q.control_method_select == METHOD_SLV0HZ
		|| cfg_q.control_method_select == METHOD_VEC_ENC);
	assign slock_ok = cfg_q.slock_assigned && !cfg_q.flux_assigned
		&& cfg_q.control_method_select == METHOD_VEC_ENC;
	assign gate     = flux_ok ? stab_q[PIN_FLUX] : (slock_ok ? stab_q[PIN_SLOCK] : 1'b1);
	assign soft_rst = rise[PIN_RST];

	// Loss of the gate while driving coasts at once; its return restarts in the set mode.
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			st_q        <= ST_IDLE;
			restart_stb <= 1'b0;
		end else begin
			restart_stb <= 1'b0;
			unique case (st_q)
				ST_IDLE: begin
					if (stab_q[PIN_RUN] && gate) begin
						st_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!gate) begin
						st_q <= ST_COAST;
					end else if (!stab_q[PIN_RUN]) begin
						st_q <= ST_IDLE;
					end
				end
				ST_COAST: begin
					if (!stab_q[PIN_RUN]) begin
						st_q <= ST_IDLE;
					end else if (gate) begin
						st_q        <= ST_RUN;
						restart_stb <= 1'b1;
					end
				end
			endcase
		end
	end

	assign drive_enable = (st_q == ST_RUN);
	assign coast_stop   = (st_q == ST_COAST);
	assign pre_excite   = flux_ok && stab_q[PIN_FLUX];
	assign restart_mode = cfg_q.restart_after_coast_mode;

	// =============================================================
	// Analog hold and up/down frequency
	// =============================================================
	logic [1:0] warm_q;
	logic       resume_q;
	logic       hold_on;

	assign hold_on = cfg_q.hold_assigned && stab_q[PIN_HOLD];

	// After power-up, or a drive reset while holding, the stored value is resumed until hold is seen low.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warm_q   <= '0;
			resume_q <= 1'b1;
		end else begin
			if (warm_q != WARM_DONE) begin
				warm_q <= warm_q + 2'h1;
			end
			if (soft_rst) begin
				resume_q <= holding_q;
			end else if (warm_q == WARM_DONE && !hold_on) begin
				resume_q <= 1'b0;
			end
		end
	end

	// Frequency base: restored, captured on hold rise, then stepped by up/down edges.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			freq_q        <= '0;
			holding_q     <= 1'b0;
			nv_store_stb  <= 1'b0;
			nv_store_data <= '0;
		end else begin
			nv_store_stb <= 1'b0;
			if (warm_q == 2'h0) begin
				freq_q <= nv_restore_data;
			end else if (hold_on && !holding_q) begin
				holding_q <= 1'b1;
				if (!resume_q) begin
					freq_q        <= analog_cmd;
					nv_store_stb  <= 1'b1;
					nv_store_data <= analog_cmd;
				end
			end else if (!hold_on) begin
				holding_q <= 1'b0;
			end else if (rise[PIN_UP] != rise[PIN_DN]) begin
				freq_q <= rise[PIN_UP] ? freq_q + FREQ_W'(FREQ_STEP) : freq_q - FREQ_W'(FREQ_STEP);
				if (cfg_q.updown_memory_select == MEM_SEL_STORE) begin
					nv_store_stb  <= 1'b1;
					nv_store_data <= rise[PIN_UP] ? freq_q + FREQ_W'(FREQ_STEP) : freq_q - FREQ_W'(FREQ_STEP);
				end
			end
		end
	end

	assign freq_ref = holding_q ? freq_q : analog_cmd;

	// =============================================================
	// Position select with settling timer
	// =============================================================
	logic [2:0]  sel;
	logic [15:0] tmr_q;
	logic        busy_q;

	assign sel = stab_q[PIN_POS +: 3] & cfg_q.pos_assigned;

	// Skewed inputs would flash intermediate indexes; each edge restarts the wait instead.
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			tmr_q     <= '0;
			busy_q    <= 1'b0;
			pos_index <= '0;
		end else if ((edge_any[PIN_POS +: 3] & cfg_q.pos_assigned) != 3'h0) begin
			tmr_q  <= settle_q;
			busy_q <= 1'b1;
		end else if (busy_q) begin
			if (tmr_q == 16'h0) begin
				pos_index <= sel;
				busy_q    <= 1'b0;
			end else begin
				tmr_q <= tmr_q - 16'h1;
			end
		end
	end

	assign stat = '{rsvd: '0, holding: holding_q, settle_busy: busy_q, pos_index: pos_index,
		excite: pre_excite, coast_stop: coast_stop, driving: drive_enable};

	// =============================================================
	// Assertions
	// =============================================================
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_run_needs_gate: assert property (st_q == ST_IDLE && !gate |=> st_q != ST_RUN)
		else $error("Run accepted without gate.");
	a_coast_on_drop: assert property (st_q == ST_RUN && !gate && !soft_rst |=> coast_stop)
		else $error("No coast after gate drop.");
	a_restart_pulse: assert property (coast_stop && gate && stab_q[PIN_RUN] && !soft_rst |=> restart_stb && drive_enable)
		else $error("No restart after coast.");
	a_slock_method: assert property (cfg_q.control_method_select != METHOD_VEC_ENC && !flux_ok |-> gate)
		else $error("Servo-lock gated in wrong method.");
	a_flux_priority: assert property (flux_ok |-> gate == stab_q[PIN_FLUX])
		else $error("Flux-forcing not in charge.");
	a_energy_clear: assert property (eclr |=> etotal_q == 32'h0 && edisp_q == 32'h0)
		else $error("Energy not cleared.");
	a_hold_capture: assert property (hold_on && !holding_q && !resume_q && warm_q != 2'h0 |=> freq_q == $past(analog_cmd))
		else $error("Hold did not capture.");
	a_settle_zero: assert property (busy_q && tmr_q == 16'h0 && edge_any[PIN_POS +: 3] == 3'h0 && !soft_rst
		|=> pos_index == $past(sel) && !busy_q)
		else $error("Index not latched on expiry.");
	a_settle_hold: assert property (busy_q && tmr_q != 16'h0 && !soft_rst |=> $stable(pos_index))
		else $error("Index changed while settling.");

	c_coast_restart: cover property (coast_stop ##[1:50] restart_stb);
	c_hold_step: cover property (holding_q && rise[PIN_UP]);
	c_pos_retrigger: cover property (busy_q && tmr_q != 16'h0 && edge_any[PIN_POS]);
	c_energy_key: cover property (rise[PIN_KEY] && cfg_q.energy_clear_select == CLR_SEL_STORE);
endmodule
`default_nettype wire

// file: difl_switches.sv
`timescale 1ns/100ps
`default_nettype none
// =============================================================
// Terminal switch bank
// =============================================================
module difl_switches
	import difl_pkg::*;
(
	input  wire logic             aclk, // Control clock.
	input  wire logic [NPINS-1:0] want, // Contact levels asked for.
	output logic      [NPINS-1:0] pins  // Contact levels at the terminals.
);
	logic [1:0] lag1_q;
	logic       lag2_q;

	// Selector contacts close one cycle apart, as real switches never close together.
	// This skew is what the settling timer has to absorb.
	initial begin
		pins = '0;
		lag1_q = '0;
		lag2_q = 1'b0;
	end

	always @(posedge aclk) begin
		pins[PIN_POS:0] <= want[PIN_POS:0];
		lag1_q <= want[PIN_POS+2:PIN_POS+1];
		lag2_q <= lag1_q[1];
		pins[PIN_POS+1] <= lag1_q[0];
		pins[PIN_POS+2] <= lag2_q;
	end
endmodule
`default_nettype wire

// file: drive_input_function_logic_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module drive_input_function_logic_tb_top;
	import difl_pkg::*;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, epulse = 0;
	logic awr, wr_r, bv, arr, rv, nv_stb, den, coast, pexc, rstb;
	logic [1:0] bresp, rresp, rmode;
	logic [2:0] pidx;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd, rdv;
	logic [15:0] acmd = 0, nv_data, fref;
	logic [NPINS-1:0] want = '0, pins;
	logic [1:0] resp;
	difl_cfg_type cfg;
	int bad_count = 0, checked = 0, cyc = 0;

	always #12.5 aclk = ~aclk;

	difl_switches sw (.aclk(aclk), .want(want), .pins(pins));

	difl_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.energy_clear_in(pins[PIN_ECLR]), .servo_lock_in(pins[PIN_SLOCK]), .flux_forcing_in(pins[PIN_FLUX]),
		.analog_hold_in(pins[PIN_HOLD]), .operator_store_key(pins[PIN_KEY]), .run_cmd_in(pins[PIN_RUN]),
		.reset_terminal(pins[PIN_RST]), .freq_up_in(pins[PIN_UP]), .freq_down_in(pins[PIN_DN]),
		.pos_sel_bit0(pins[PIN_POS]), .pos_sel_bit1(pins[PIN_POS+1]), .pos_sel_bit2(pins[PIN_POS+2]),
		.energy_pulse(epulse), .analog_cmd(acmd), .nv_restore_data(16'h0000), .nv_store_stb(nv_stb),
		.nv_store_data(nv_data), .freq_ref(fref), .drive_enable(den), .coast_stop(coast), .pre_excite(pexc),
		.restart_stb(rstb), .restart_mode(rmode), .pos_index(pidx));

	// =============================================================
	// Shared tasks
	// =============================================================
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// A hung handshake would stall forever, so the cycle ceiling ends the run.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, seen, exp);
		end
	endtask

	// Settles for n edges, then steps past the edge so outputs have landed.
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask

	// Handshakes are judged from values settled 1 ns after the previous edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		@(posedge aclk);
		awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
		do begin
			#1; ah = awv && awr; wh = wv && wr_r; bh = bv; resp = bresp;
			@(posedge aclk);
			if (ah) awv <= 0;
			if (wh) wv <= 0;
		end while (!bh);
		br <= 0;
	endtask

	task automatic rdr(input logic [7:0] a);
		logic ah, rh;
		@(posedge aclk);
		ara <= a; arv <= 1; rr <= 1;
		do begin
			#1; ah = arv && arr; rh = rv; rdv = rd; resp = rresp;
			@(posedge aclk);
			if (ah) arv <= 0;
		end while (!rh);
		rr <= 0;
	endtask

	task automatic pin(input int i, input logic v, input int n);
		@(posedge aclk);
		want[i] <= v;
		wt(n);
	endtask

	task automatic hw_reset(input difl_cfg_type c);
		@(posedge aclk);
		want <= '0; aresetn <= 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		wr(ADDR_CFG, c);
		wt(8);
	endtask

	// =============================================================
	// Scenarios
	// =============================================================
	task automatic t_energy();
		cfg = '0; cfg.eclr_assigned = 1; cfg.energy_clear_select = CLR_SEL_STORE;
		hw_reset(cfg);
		rdr(ADDR_GAIN); chk(rdv, 32'h1, "gain reset");
		wr(ADDR_GAIN, 32'h0); wr(ADDR_GAIN, 32'h3e9); rdr(ADDR_GAIN); chk(rdv, 32'h1, "gain limits");
		wr(ADDR_GAIN, 32'h2); chk(resp, RESP_OKAY, "write okay");
		rdr(8'h1c); chk(resp, RESP_SLVERR, "unmapped read");
		wr(ADDR_STATUS, 32'h1); chk(resp, RESP_SLVERR, "read-only write");
		@(posedge aclk); epulse <= 1; repeat (5) @(posedge aclk); epulse <= 0;
		rdr(ADDR_ETOTAL); chk(rdv, 32'h5, "energy total");
		rdr(ADDR_EDISP); chk(rdv, 32'h2, "energy display");
		pin(PIN_ECLR, 1, 10); pin(PIN_ECLR, 0, 10);
		rdr(ADDR_ETOTAL); chk(rdv, 32'h0, "clear by pin");
		@(posedge aclk); epulse <= 1; repeat (3) @(posedge aclk); epulse <= 0;
		pin(PIN_KEY, 1, 10); pin(PIN_KEY, 0, 10);
		rdr(ADDR_ETOTAL); chk(rdv, 32'h0, "clear by key");
	endtask

	task automatic t_lock();
		logic seen;
		cfg = '0; cfg.control_method_select = METHOD_VEC_ENC; cfg.slock_assigned = 1;
		cfg.restart_after_coast_mode = 2'h2;
		hw_reset(cfg);
		pin(PIN_RUN, 1, 10); chk(den, 1'b0, "run refused");
		pin(PIN_SLOCK, 1, 10); chk(den, 1'b1, "run accepted");
		pin(PIN_SLOCK, 0, 10); chk({coast, den}, 2'b10, "lock drop coasts");
		seen = 0;
		pin(PIN_SLOCK, 1, 0);
		repeat (20) begin wt(1); seen |= rstb; end
		chk(seen, 1'b1, "restart pulse");
		chk(rmode, 2'h2, "restart mode");
		cfg.control_method_select = METHOD_SLV; hw_reset(cfg);
		pin(PIN_RUN, 1, 10); chk(den, 1'b1, "lock ignored off method 05");
		cfg.control_method_select = METHOD_VEC_ENC; cfg.flux_assigned = 1; hw_reset(cfg);
		pin(PIN_FLUX, 1, 10); chk(pexc, 1'b1, "excitation on");
		pin(PIN_RUN, 1, 10); chk(den, 1'b1, "flux wins over lock");
		pin(PIN_FLUX, 0, 10); chk({coast, den}, 2'b10, "flux drop coasts");
		rdr(ADDR_STATUS); chk(rdv, 32'h2, "status coasting");
		cfg.control_method_select = 4'h2; hw_reset(cfg);
		pin(PIN_FLUX, 1, 10); chk(pexc, 1'b0, "flux off method 02");
		cfg.control_method_select = METHOD_SLV0HZ; hw_reset(cfg);
		pin(PIN_FLUX, 1, 10); chk(pexc, 1'b1, "flux on method 04");
	endtask

	task automatic t_hold();
		logic seen;
		cfg = '0; cfg.hold_assigned = 1; cfg.updown_memory_select = MEM_SEL_STORE;
		hw_reset(cfg);
		@(posedge aclk); acmd <= 16'h1234;
		pin(PIN_HOLD, 1, 10);
		@(posedge aclk); acmd <= 16'h0500;
		wt(2); chk(fref, 16'h1234, "held level");
		pin(PIN_UP, 1, 10); pin(PIN_UP, 0, 10);
		chk(fref, 16'h1235, "up from held base");
		chk(nv_data, 16'h1235, "up stored");
		rdr(ADDR_FREQ); chk(rdv, 32'h1235, "freq readback");
		seen = 0;
		pin(PIN_DN, 1, 0);
		repeat (12) begin wt(1); seen |= nv_stb; end
		chk(seen, 1'b1, "store strobe");
		pin(PIN_DN, 0, 10); chk(nv_data, 16'h1234, "down stored");
		pin(PIN_RST, 1, 10); pin(PIN_RST, 0, 10);
		chk(fref, 16'h1234, "held through reset");
		pin(PIN_HOLD, 0, 10); chk(fref, 16'h0500, "hold released");
	endtask

	task automatic t_pos();
		cfg = '0; cfg.pos_assigned = 3'h7;
		hw_reset(cfg);
		wr(ADDR_SETTLE, 32'h6);
		@(posedge aclk); want[PIN_POS+2:PIN_POS] <= 3'h5;
		wt(7); chk(pidx, 3'h0, "index waits");
		@(posedge aclk); want[PIN_POS+1] <= 1'b1;
		wt(7); chk(pidx, 3'h0, "retriggered");
		wt(20); chk(pidx, 3'h7, "latched together");
		wr(ADDR_SETTLE, 32'h0);
		@(posedge aclk); want[PIN_POS+2:PIN_POS] <= 3'h2;
		wt(15); chk(pidx, 3'h2, "zero delay");
		cfg.pos_assigned = 3'h0; hw_reset(cfg);
		@(posedge aclk); want[PIN_POS+2:PIN_POS] <= 3'h7;
		wt(20); chk(pidx, 3'h0, "unassigned selects zero");
	endtask

	initial begin
		t_energy();
		t_lock();
		t_hold();
		t_pos();
		print_verdict();
	end
endmodule
`default_nettype wire
